// ---- logic/bfgs_consts.svh ----
`ifndef BFGS_CONSTS_SVH
`define BFGS_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and oscillator timing
// ----------------------------------------------------------------
`define BFGS_CLK_HZ         200000000
`define BFGS_OSC_HZ         600000
`define BFGS_OSC_PERIOD_CYC (`BFGS_CLK_HZ / `BFGS_OSC_HZ)
`define BFGS_OSC_HALF_CYC   (`BFGS_OSC_PERIOD_CYC / 2)

// ----------------------------------------------------------------
// Restart delay and duty-cycle timeout
// ----------------------------------------------------------------
`define BFGS_RESTART_MS     200
`define BFGS_RESTART_OSC    (`BFGS_RESTART_MS * (`BFGS_OSC_HZ / 1000))
`define BFGS_TIMEOUT_CYC    20

// ----------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------
`define BFGS_IN_VCC_LOCK    0
`define BFGS_IN_VIN_LOCK    1
`define BFGS_IN_THERMAL     2
`define BFGS_IN_SHORT       3
`define BFGS_IN_COMPARE     4
`define BFGS_IN_SS_ABOVE    5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BFGS_RST_GATE       1'b0
`define BFGS_RST_PULLDOWN   1'b1
`define BFGS_RST_SYNC       6'h03    // Both lockout bits read as fault

`endif

// ---- logic/bfgs_pkg.sv ----
package bfgs_pkg;

	// ----------------------------------------------------------------
	// Fault sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BFGS_ST_LOCKOUT = 3'h1,   // Idle until lockout clears
		BFGS_ST_DELAY   = 3'h2,   // Idle while restart delay runs
		BFGS_ST_RUN     = 3'h4    // Switching
	} bfgs_fsm_t;

	// ----------------------------------------------------------------
	// Whole state of the sequencer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0]  sync1;      // First synchroniser stage
		logic [5:0]  sync2;      // Second synchroniser stage
		bfgs_fsm_t   state;
		logic [8:0]  phase;      // Position within oscillator period
		logic [16:0] timer;      // Restart delay, oscillator cycles
		logic [4:0]  on_cnt;     // Full cycles with high side on
		logic        pwm_ff;     // PWM flip-flop
		logic        full_on;    // High side on through this cycle
		logic        force_low;  // Forced low-side refresh
		logic        ls_en;      // Low side released after startup
		logic        hs;
		logic        ls;
		logic        ss_pd;
		logic        comp_pd;
	} bfgs_state_t;

endpackage : bfgs_pkg

// ---- logic/bfgs_sequencer.sv ----

`include "bfgs_consts.svh"

module bfgs_sequencer import bfgs_pkg::*; #(
	parameter int RESTART_OSC_CYCLES = `BFGS_RESTART_OSC
) (
	input  wire logic ref_clk_in,
	input  wire logic arst_n_in,
	input  wire logic bias_lockout_in,
	input  wire logic input_lockout_sense_in,
	input  wire logic thermal_fault_in,
	input  wire logic short_fault_in,
	input  wire logic pwm_compare_in,
	input  wire logic ss_above_thresh_in,
	output logic      high_side_gate_out,
	output logic      low_side_gate_drive_out,
	output logic      ss_pulldown_out,
	output logic      comp_pulldown_out,
	output logic      supply_lockout_fault_out,
	output logic      osc_tick_out
);

	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam logic [8:0] OSC_LAST =
		9'(`BFGS_OSC_PERIOD_CYC - 1);
	localparam logic [8:0] OSC_HALF = 9'(`BFGS_OSC_HALF_CYC);
	localparam logic [16:0] TIMER_LAST = 17'(RESTART_OSC_CYCLES - 1);
	localparam logic [4:0] TIMEOUT = 5'(`BFGS_TIMEOUT_CYC);

	// Lockout bits of both synchroniser stages reset to fault present,
	// so the sequencer stays idle until the real pin levels arrive
	localparam bfgs_state_t RST_STATE = '{
		sync1:     `BFGS_RST_SYNC,
		sync2:     `BFGS_RST_SYNC,
		state:     BFGS_ST_LOCKOUT,
		phase:     9'h000,
		timer:     17'h00000,
		on_cnt:    5'h00,
		pwm_ff:    1'b0,
		full_on:   1'b0,
		force_low: 1'b0,
		ls_en:     1'b0,
		hs:        `BFGS_RST_GATE,
		ls:        `BFGS_RST_GATE,
		ss_pd:     `BFGS_RST_PULLDOWN,
		comp_pd:   `BFGS_RST_PULLDOWN
	};

	// ----------------------------------------------------------------
	// State and decoded synchronised inputs
	// ----------------------------------------------------------------
	bfgs_state_t r;
	bfgs_state_t next_r;

	logic osc_tick;
	logic lockout;
	logic thermal;
	logic short_flt;
	logic compare;
	logic ss_above;
	logic running;

	// Oscillator period boundary and synchronised comparator levels
	assign osc_tick  = (r.phase == OSC_LAST);
	assign lockout   = r.sync2[`BFGS_IN_VCC_LOCK] |
	                   r.sync2[`BFGS_IN_VIN_LOCK];
	assign thermal   = r.sync2[`BFGS_IN_THERMAL];
	assign short_flt = r.sync2[`BFGS_IN_SHORT];
	assign compare   = r.sync2[`BFGS_IN_COMPARE];
	assign ss_above  = r.sync2[`BFGS_IN_SS_ABOVE];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Synchroniser, oscillator, fault sequencer, PWM and gate control
	always_comb begin
		next_r = r;

		// Two flip-flops on every comparator input
		next_r.sync1 = {ss_above_thresh_in, pwm_compare_in,
		                short_fault_in, thermal_fault_in,
		                input_lockout_sense_in, bias_lockout_in};
		next_r.sync2 = r.sync1;

		// Free-running oscillator period counter
		if (osc_tick) begin
			next_r.phase = 9'h000;
		end else begin
			next_r.phase = r.phase + 9'h001;
		end

		// Fault sequencer, lockout has priority over the timed faults
		case (r.state)
			BFGS_ST_LOCKOUT: begin
				if (!lockout) begin
					if (thermal || short_flt) begin
						next_r.state = BFGS_ST_DELAY;
						next_r.timer = 17'h00000;
					end else begin
						next_r.state = BFGS_ST_RUN;
					end
				end
			end
			BFGS_ST_DELAY: begin
				if (lockout) begin
					next_r.state = BFGS_ST_LOCKOUT;
				end else if (thermal) begin
					next_r.timer = 17'h00000;
				end else if (osc_tick) begin
					if (r.timer >= TIMER_LAST) begin
						next_r.state = BFGS_ST_RUN;
						next_r.timer = 17'h00000;
					end else begin
						next_r.timer = r.timer + 17'h00001;
					end
				end
			end
			BFGS_ST_RUN: begin
				if (lockout) begin
					next_r.state = BFGS_ST_LOCKOUT;
				end else if (thermal || short_flt) begin
					next_r.state = BFGS_ST_DELAY;
					next_r.timer = 17'h00000;
				end
			end
			default: begin
				next_r.state = BFGS_ST_LOCKOUT;
				next_r.timer = 17'h00000;
			end
		endcase

		// Switching allowed in the coming cycle
		running = (next_r.state == BFGS_ST_RUN);

		// PWM flip-flop and duty-cycle timeout
		if (!running) begin
			next_r.pwm_ff    = 1'b0;
			next_r.full_on   = 1'b0;
			next_r.on_cnt    = 5'h00;
			next_r.force_low = 1'b0;
			next_r.ls_en     = 1'b0;
		end else if (osc_tick) begin
			// New cycle: set on compare, count completed full-on cycles
			next_r.force_low = 1'b0;
			next_r.pwm_ff    = compare;
			next_r.full_on   = compare;
			if (r.full_on && r.pwm_ff && (r.on_cnt < TIMEOUT)) begin
				next_r.on_cnt = r.on_cnt + 5'h01;
			end else if (!(r.full_on && r.pwm_ff)) begin
				next_r.on_cnt = 5'h00;
			end
		end else if (r.pwm_ff && (r.on_cnt == TIMEOUT) &&
		             (r.phase == OSC_HALF)) begin
			// Forced mid-cycle reset after the timeout
			next_r.pwm_ff    = 1'b0;
			next_r.full_on   = 1'b0;
			next_r.force_low = 1'b1;
		end else if (!compare) begin
			// Trailing edge: ramp crossed the error voltage
			next_r.pwm_ff  = 1'b0;
			next_r.full_on = 1'b0;
		end

		// Low side released once high side tried or soft-start is up
		if (running && (next_r.pwm_ff || ss_above)) begin
			next_r.ls_en = 1'b1;
		end

		// Registered gate drives and idle pull-downs
		next_r.hs      = running && next_r.pwm_ff;
		next_r.ls      = running && next_r.ls_en &&
		                 !next_r.pwm_ff;
		next_r.ss_pd   = !running;
		next_r.comp_pd = !running;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Single register holding the whole state
	// Reset holds every gate off and both pull-downs on
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= RST_STATE;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// Gate drives and pull-downs straight from flip-flops; lockout flag and tick decoded from state and phase
	assign high_side_gate_out       = r.hs;
	assign low_side_gate_drive_out  = r.ls;
	assign ss_pulldown_out          = r.ss_pd;
	assign comp_pulldown_out        = r.comp_pd;
	assign supply_lockout_fault_out = (r.state == BFGS_ST_LOCKOUT);
	assign osc_tick_out             = osc_tick;

endmodule : bfgs_sequencer

// ---- sim/bfgs_sequencer_asserts.sv ----
module bfgs_sequencer_asserts #(
	parameter int RESTART_OSC_CYCLES = 4
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic bias_lockout_in,
	input wire logic input_lockout_sense_in,
	input wire logic thermal_fault_in,
	input wire logic short_fault_in,
	input wire logic pwm_compare_in,
	input wire logic ss_above_thresh_in,
	input wire logic high_side_gate_out,
	input wire logic low_side_gate_drive_out,
	input wire logic ss_pulldown_out,
	input wire logic comp_pulldown_out,
	input wire logic supply_lockout_fault_out,
	input wire logic osc_tick_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER  = 333;
	localparam int RMAX = (RESTART_OSC_CYCLES + 2) * PER + 8;
	localparam int RMIN = (RESTART_OSC_CYCLES - 1) * PER;
	logic [15:0] hs_run;
	logic [15:0] quiet;
	logic        seen;
	logic        last_lock;
	logic        lock_f;
	logic        any_f;
	// Fault summaries
	assign lock_f = bias_lockout_in | input_lockout_sense_in;
	assign any_f  = lock_f | thermal_fault_in | short_fault_in;
	// High-side run length, quiet time, low-side release
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hs_run    <= 16'h0;
			quiet     <= 16'h0;
			seen      <= 1'b0;
			last_lock <= 1'b1;
		end else begin
			hs_run <= high_side_gate_out ? hs_run + 16'h1 : 16'h0;
			quiet  <= any_f ? 16'h0 : quiet + 16'h1;
			seen   <= !ss_pulldown_out &
				(seen | high_side_gate_out | ss_above_thresh_in);
			if (any_f)
				last_lock <= lock_f;
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_idle_outputs: assert property (supply_lockout_fault_out |->
		ss_pulldown_out && comp_pulldown_out && !high_side_gate_out &&
		!low_side_gate_drive_out) else $error("lockout idle not quiet");
	a_fault_idles: assert property (any_f |-> ##[3:4]
		(ss_pulldown_out && comp_pulldown_out && !high_side_gate_out))
		else $error("fault did not idle");
	a_lockout_holds: assert property (lock_f |-> ##[3:4]
		supply_lockout_fault_out) else $error("lockout not held");
	a_ls_release: assert property (low_side_gate_drive_out |->
		seen) else $error("low side before release");
	a_timeout_max: assert property (hs_run <= 20 * PER + 168)
		else $error("high side on too long");
	a_refresh_low: assert property ($fell(high_side_gate_out) &&
		hs_run > 20 * PER && !ss_pulldown_out |->
		low_side_gate_drive_out [*8]) else $error("no refresh pulse");
	a_osc_period: assert property (osc_tick_out |->
		##[333:333] osc_tick_out) else $error("oscillator period");
	a_duty_zero: assert property (!pwm_compare_in [*4] |->
		##1 !high_side_gate_out) else $error("high side without demand");
	a_restart_max: assert property (quiet > RMAX |->
		!ss_pulldown_out) else $error("restart too late");
	a_restart_min: assert property ($fell(ss_pulldown_out) &&
		!last_lock |-> quiet >= RMIN) else $error("restart too early");
	c_refresh: cover property ($fell(high_side_gate_out) && hs_run > 6660);
	c_delay_restart: cover property ($fell(ss_pulldown_out) && !last_lock);
	c_lockout: cover property ($rose(supply_lockout_fault_out));
endmodule : bfgs_sequencer_asserts

// ---- sim/bfgs_comparator_model.sv ----
module bfgs_comparator_model (
	input  wire logic       ref_clk_in,
	input  wire logic [9:0] duty_in,
	input  wire logic       ss_pulldown_in,
	output logic            pwm_compare_out,
	output logic            ss_above_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] ramp;
	logic [9:0] ss_lvl;
	initial begin
		ramp = 9'h0;
		ss_lvl = 10'h0;
	end
	// Free ramp, unrelated in phase; soft-start charges when released
	always @(negedge ref_clk_in) begin
		ramp <= (ramp == 9'h14c) ? 9'h0 : ramp + 9'h1;
		ss_lvl <= ss_pulldown_in ? 10'h0 : ss_lvl + {9'h0, ss_lvl != 10'h3ff};
	end
	// Comparator outputs
	assign pwm_compare_out = {1'b0, ramp} < duty_in;
	assign ss_above_out = ss_lvl > 10'h258;
endmodule : bfgs_comparator_model

// ---- sim/bfgs_sequencer_tb_top.sv ----
module bfgs_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RST = 4;
	localparam int LO  = (RST - 1) * 333 - 8;
	localparam int HI  = (RST + 1) * 333 + 8;
	logic       clk, rst_n, bias, vin, therm, shrt, cmp, ssa, pd_prev;
	logic       hs, ls, ss_pd, comp_pd, lock, tick;
	logic [1:0] e;
	logic [9:0] duty;
	logic [1:0] exp_q[$];
	int         num_errors, check_count, w, gap, ticks;
	// Clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	bfgs_sequencer #(.RESTART_OSC_CYCLES(RST)) u_bfgs_sequencer (
		.ref_clk_in(clk), .arst_n_in(rst_n), .bias_lockout_in(bias),
		.input_lockout_sense_in(vin), .thermal_fault_in(therm),
		.short_fault_in(shrt), .pwm_compare_in(cmp),
		.ss_above_thresh_in(ssa), .high_side_gate_out(hs),
		.low_side_gate_drive_out(ls), .ss_pulldown_out(ss_pd),
		.comp_pulldown_out(comp_pd), .supply_lockout_fault_out(lock),
		.osc_tick_out(tick));
	bfgs_comparator_model u_bfgs_comparator_model (.ref_clk_in(clk),
		.duty_in(duty), .ss_pulldown_in(ss_pd), .pwm_compare_out(cmp),
		.ss_above_out(ssa));
	task automatic check_bit(string what, logic exp, logic got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : check_bit
	task automatic check_cnt(string what, int lo, int hi, int got);
		check_count++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_cnt
	task automatic wait_run();
		w = 0;
		while (ss_pd !== 1'b0 && w < HI + 30) begin
			@(negedge clk);
			w++;
		end
		check_bit("restart", 1'b0, ss_pd);
	endtask : wait_run
	task automatic pulse(ref logic f, input int hold, input logic lk);
		exp_q.push_back({1'b1, lk});
		f = 1'b1;
		repeat (hold) @(negedge clk);
		f = 1'b0;
		exp_q.push_back(2'b00);
		wait_run();
	endtask : pulse
	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// Each pulldown change is matched with the oldest note
	always @(negedge clk) begin
		if (rst_n === 1'b1 && ss_pd !== pd_prev) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 2'bxx;
			check_bit("ss_pulldown", e[1], ss_pd);
			check_bit("comp_pulldown", e[1], comp_pd);
			check_bit("lockout_flag", e[0], lock);
		end
		pd_prev = ss_pd;
		check_bit("gate_overlap", 1'b0, hs & ls);
		// Every oscillator period spans 333 clocks
		if (rst_n === 1'b1) begin
			gap++;
			if (tick === 1'b1) begin
				if (ticks > 0)
					check_cnt("osc_period", 333, 333, gap);
				ticks++;
				gap = 0;
			end
		end
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{bias, vin, therm, shrt} = 4'h0;
		duty = 10'h0;
		pd_prev = 1'b1;
		num_errors = 0;
		check_count = 0;
		gap = 0;
		ticks = 0;
		void'($urandom(58034));
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		exp_q.push_back(2'b00);
		wait_run();
		check_bit("ls_before_ss", 1'b0, ls);
		repeat (700) @(negedge clk);
		check_bit("ls_after_ss", 1'b1, ls);
		pulse(bias, 50, 1'b1);
		pulse(vin, 50, 1'b1);
		pulse(shrt, 4, 1'b0);
		check_cnt("short_restart", LO, HI, w);
		pulse(therm, 3000, 1'b0);
		check_cnt("thermal_restart", LO, HI, w);
		duty = 10'h3ff;
		w = 0;
		while (hs !== 1'b1 && w < 2000) begin
			@(negedge clk);
			w++;
		end
		w = 0;
		while (hs === 1'b1 && w < 8000) begin
			@(negedge clk);
			w++;
		end
		check_cnt("full_on_run", 6826, 6828, w);
		check_bit("refresh_low", 1'b1, ls);
		repeat (40) begin
			duty = 10'($urandom_range(333));
			repeat (100) @(negedge clk);
		end
		check_cnt("notes_left", 0, 0, exp_q.size());
		end_sim();
	end
	// Watchdog
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
endmodule : bfgs_sequencer_tb_top

bind bfgs_sequencer bfgs_sequencer_asserts #(
	.RESTART_OSC_CYCLES(RESTART_OSC_CYCLES)
) u_bfgs_sequencer_asserts (.*);
